// *** rtl/cat_pkg.sv ***
package cat_pkg;
	// byte addresses on the register bus
	localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
	localparam logic [7:0] ADDR_MODE       = 8'h08;
	localparam logic [7:0] ADDR_FLAGS      = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_PIN_ENABLE = 8'h14;

	localparam int COUNT_W    = 16;
	localparam int CHANNELS   = 6;
	localparam int EVENTS     = 8;
	localparam int PART_BASE  = 7;
	localparam int FLAG_CF    = 0;
	localparam int FLAG_PARTIAL_OVERFLOW_FLAG  = 1;
	localparam int FLAG_CH0   = 2;
	localparam int MODE_W     = 7;

	localparam int DIV_SLOW   = 12;
	localparam int DIV_FAST   = 4;
	localparam int DIV_OSC    = 8;

	typedef enum logic [2:0] {
		CAT_TB_DIV12,
		CAT_TB_DIV4,
		CAT_TB_T0,
		CAT_TB_ECI,
		CAT_TB_SYS,
		CAT_TB_EXT8,
		CAT_TB_LFO8,
		CAT_TB_RSVD
	} cat_tb_t;

	typedef struct packed {
		logic       watchdog_mode;
		logic [1:0] cycle_length_select;
		cat_tb_t    timebase_select;
		logic       idle_suspend;
	} cat_mode_t;

	// watchdog mode comes out of reset enabled
	localparam cat_mode_t MODE_RESET = 7'h40;

	typedef struct packed {
		logic timer0_overflow;
		logic external_count_input;
		logic ext_osc;
		logic lf_osc;
	} cat_src_t;
endpackage : cat_pkg

// *** rtl/cat_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module cat_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule : cat_sync
`default_nettype wire

// *** rtl/cat_timebase.sv ***
`timescale 1ns/1ps
`default_nettype none
module cat_timebase (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire cat_pkg::cat_tb_t sel,
	input  wire cat_pkg::cat_src_t src,
	output logic                  tick
);
	logic [3:0] div12_reg;
	logic [1:0] div4_reg;
	logic [2:0] ext_div_reg;
	logic [2:0] lfo_div_reg;
	logic [2:0] pins_sync;
	logic [2:0] pins_last_reg;
	logic       eci_fall;
	logic       ext_rise;
	logic       lfo_rise;

	// pins pass two flops before anything looks at them
	cat_sync #(.WIDTH(3)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({src.external_count_input, src.ext_osc, src.lf_osc}),
		.sync_out (pins_sync)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pins_last_reg <= '0;
		else
			pins_last_reg <= pins_sync;
	end

	assign eci_fall = pins_last_reg[2] && !pins_sync[2];
	assign ext_rise = !pins_last_reg[1] && pins_sync[1];
	assign lfo_rise = !pins_last_reg[0] && pins_sync[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div12_reg   <= '0;
			div4_reg    <= '0;
			ext_div_reg <= '0;
			lfo_div_reg <= '0;
		end else begin
			div12_reg <= (div12_reg == 4'(cat_pkg::DIV_SLOW - 1)) ? '0
				: div12_reg + 4'h1;
			div4_reg <= div4_reg + 2'h1;
			if (ext_rise)
				ext_div_reg <= ext_div_reg + 3'h1;
			if (lfo_rise)
				lfo_div_reg <= lfo_div_reg + 3'h1;
		end
	end

	// one-cycle count enable for the selected source
	always_comb begin
		tick = 1'b0;
		case (sel)
			cat_pkg::CAT_TB_DIV12: tick = div12_reg == 4'(cat_pkg::DIV_SLOW - 1);
			cat_pkg::CAT_TB_DIV4:  tick = div4_reg == 2'(cat_pkg::DIV_FAST - 1);
			cat_pkg::CAT_TB_T0:    tick = src.timer0_overflow;
			cat_pkg::CAT_TB_ECI:   tick = eci_fall;
			cat_pkg::CAT_TB_SYS:   tick = 1'b1;
			cat_pkg::CAT_TB_EXT8:
				tick = ext_rise && ext_div_reg == 3'(cat_pkg::DIV_OSC - 1);
			cat_pkg::CAT_TB_LFO8:
				tick = lfo_rise && lfo_div_reg == 3'(cat_pkg::DIV_OSC - 1);
			default:               tick = 1'b0;
		endcase
	end
endmodule : cat_timebase
`default_nettype wire

// *** rtl/cat_counter_array.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - 16-bit up-counter read and written as low and high byte registers.
// - reading the low byte latches the high byte; high read returns latch.
// - register reads never disturb counting.
// - 3-bit select picks one of seven count sources; code 7 stops.
// - divided oscillator sources are synchronised before advancing count.
// - wrap from all ones to zero sets the counter overflow flag.
// - counter overflow flag interrupts only while its enable is set.
// - with idle suspend off, counting continues while the core idles.
// - carry out of the selected bit (8, 9, 10 or 11) sets the partial overflow flag.
// - each of six channels owns an event flag set by its logic.
// - flags set on their trigger regardless of interrupt enables.
// - eight flags, each gated by its own enable, form one request.
// - each channel line reaches its pin only when enabled.
// - watchdog mode is on after reset and locks some registers.
// - 2-bit cycle length select picks the partial overflow bit.
module cat_counter_array (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  cpu_idle,
	input  wire cat_pkg::cat_src_t     count_sources,
	input  wire logic [5:0]            channel_event,
	input  wire logic [5:0]            channel_io_line,
	output logic      [5:0]            channel_pin_out,
	output logic      [5:0]            channel_pin_oe,
	output logic      [15:0]           count_value,
	output logic      [1:0]            cycle_length_select,
	output logic                       watchdog_mode,
	output logic                       irq_request
);
	cat_pkg::cat_mode_t mode_reg;
	logic [15:0] count_reg;
	logic [7:0]  snapshot_reg;
	logic [7:0]  flags_reg;
	logic [7:0]  irq_enable_reg;
	logic [5:0]  pin_enable_reg;
	logic        tick;
	logic        advance;
	logic        wrap;
	logic        part_carry;
	logic        setup_phase;
	logic        access_done;
	logic        wr_done;
	logic        rd_done;
	logic        mapped;
	logic [7:0]  flag_set;
	logic [7:0]  flag_clear;

	function automatic logic carry_out(input logic [15:0] value,
		input logic [1:0] cls);
		logic [3:0] ones;
		ones = {&value[10:0], &value[9:0], &value[8:0], &value[7:0]};
		carry_out = ones[cls];
	endfunction : carry_out

	function automatic logic is_mapped(input logic [7:0] addr);
		is_mapped = addr == cat_pkg::ADDR_COUNT_LOW
			|| addr == cat_pkg::ADDR_COUNT_HIGH
			|| addr == cat_pkg::ADDR_MODE
			|| addr == cat_pkg::ADDR_FLAGS
			|| addr == cat_pkg::ADDR_IRQ_ENABLE
			|| addr == cat_pkg::ADDR_PIN_ENABLE;
	endfunction : is_mapped

	cat_timebase u_timebase (
		.pclk    (pclk),
		.presetn (presetn),
		.sel     (mode_reg.timebase_select),
		.src     (count_sources),
		.tick    (tick)
	);

	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready;
	assign wr_done     = access_done && pwrite && !pslverr;
	assign rd_done     = access_done && !pwrite && !pslverr;
	assign mapped      = is_mapped(paddr);

	// idle only stalls the count when software asked for it
	assign advance    = tick && !(mode_reg.idle_suspend && cpu_idle);
	assign wrap       = advance && &count_reg;
	assign part_carry = advance
		&& carry_out(count_reg, mode_reg.cycle_length_select);

	// zero wait states: every transfer finishes in its first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase && !mapped;
		end
	end

	// read data and the high byte latch are taken at the setup edge, so
	// both bytes of one low read describe the same count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup_phase && !pwrite) begin
			if (paddr == cat_pkg::ADDR_COUNT_LOW)
				prdata <= {24'h0, count_reg[7:0]};
			else if (paddr == cat_pkg::ADDR_COUNT_HIGH)
				prdata <= {24'h0, snapshot_reg};
			else if (paddr == cat_pkg::ADDR_MODE)
				prdata <= {25'h0, mode_reg};
			else if (paddr == cat_pkg::ADDR_FLAGS)
				prdata <= {24'h0, flags_reg};
			else if (paddr == cat_pkg::ADDR_IRQ_ENABLE)
				prdata <= {24'h0, irq_enable_reg};
			else if (paddr == cat_pkg::ADDR_PIN_ENABLE)
				prdata <= {26'h0, pin_enable_reg};
			else
				prdata <= '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			snapshot_reg <= '0;
		else if (setup_phase && !pwrite && paddr == cat_pkg::ADDR_COUNT_LOW)
			snapshot_reg <= count_reg[15:8];
	end

	// software writes to the count bytes are refused while the watchdog owns the unit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= '0;
		end else if (wr_done && !mode_reg.watchdog_mode
			&& paddr == cat_pkg::ADDR_COUNT_LOW) begin
			count_reg[7:0] <= pwdata[7:0];
		end else if (wr_done && !mode_reg.watchdog_mode
			&& paddr == cat_pkg::ADDR_COUNT_HIGH) begin
			count_reg[15:8] <= pwdata[7:0];
		end else if (advance) begin
			count_reg <= count_reg + 16'h1;
		end
	end

	// while locked only the watchdog bit itself may be written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= cat_pkg::MODE_RESET;
		end else if (wr_done && paddr == cat_pkg::ADDR_MODE) begin
			if (mode_reg.watchdog_mode)
				mode_reg.watchdog_mode <= pwdata[6];
			else
				mode_reg <= pwdata[6:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_reg <= '0;
			pin_enable_reg <= '0;
		end else if (wr_done) begin
			if (paddr == cat_pkg::ADDR_IRQ_ENABLE)
				irq_enable_reg <= pwdata[7:0];
			else if (paddr == cat_pkg::ADDR_PIN_ENABLE)
				pin_enable_reg <= pwdata[5:0];
		end
	end

	// flags set on their trigger whatever the enables hold
	assign flag_set = {channel_event, part_carry, wrap};
	// a read clears only what it reported, and a new event wins
	assign flag_clear = (rd_done && paddr == cat_pkg::ADDR_FLAGS)
		? prdata[7:0] : 8'h00;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flags_reg <= '0;
		else
			flags_reg <= (flags_reg & ~flag_clear) | flag_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq_request <= 1'b0;
		else
			irq_request <= |(flags_reg & irq_enable_reg);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_pin_out <= '0;
			channel_pin_oe  <= '0;
		end else begin
			channel_pin_out <= channel_io_line & pin_enable_reg;
			channel_pin_oe  <= pin_enable_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_value         <= '0;
			cycle_length_select <= '0;
			watchdog_mode       <= 1'b1;
		end else begin
			count_value         <= count_reg;
			cycle_length_select <= mode_reg.cycle_length_select;
			watchdog_mode       <= mode_reg.watchdog_mode;
		end
	end

	// checks on the logic above
	count_step_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		advance && !wr_done |=> count_reg == $past(count_reg) + 16'h1)
		else $error("count did not step on an enabled tick");

	idle_hold_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_reg.idle_suspend && cpu_idle && !wr_done
		|=> count_reg == $past(count_reg))
		else $error("count moved while suspended in idle");

	idle_run_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!mode_reg.idle_suspend && cpu_idle && tick && !wr_done
		|=> count_reg != $past(count_reg))
		else $error("count stalled in idle without suspend");

	wrap_flag_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		advance && count_reg == 16'hffff && !wr_done
		|=> count_reg == 16'h0000 && flags_reg[cat_pkg::FLAG_CF])
		else $error("wrap did not set the overflow flag");

	part_flag_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		advance && mode_reg.cycle_length_select == 2'h0
		&& count_reg[7:0] == 8'hff
		|=> flags_reg[cat_pkg::FLAG_PARTIAL_OVERFLOW_FLAG])
		else $error("carry out of bit 8 missed");

	// low read, access, one idle cycle, then the high read
	snap_read_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup_phase && !pwrite && paddr == cat_pkg::ADDR_COUNT_LOW
		##1 access_done ##1 !psel ##1 setup_phase && !pwrite
		&& paddr == cat_pkg::ADDR_COUNT_HIGH ##1 access_done
		|-> prdata[7:0] == $past(count_reg[15:8], 4))
		else $error("high read did not return the latched byte");

	irq_gate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(flags_reg & irq_enable_reg) == 8'h00 |-> !irq_request)
		else $error("request without an enabled flag");

	cf_irq_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		flags_reg[cat_pkg::FLAG_CF] && irq_enable_reg[cat_pkg::FLAG_CF]
		|=> irq_request)
		else $error("enabled overflow flag gave no request");

	wdt_lock_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_done && mode_reg.watchdog_mode
		&& paddr == cat_pkg::ADDR_COUNT_LOW && !advance
		|=> count_reg == $past(count_reg))
		else $error("count written while locked");

	pin_gate_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!pin_enable_reg[0] |=> !channel_pin_oe[0] && !channel_pin_out[0])
		else $error("disabled channel line reached its pin");

	partial_overflow_flag_irq_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		flags_reg[cat_pkg::FLAG_PARTIAL_OVERFLOW_FLAG]
		&& irq_enable_reg[cat_pkg::FLAG_PARTIAL_OVERFLOW_FLAG] |=> irq_request)
		else $error("enabled partial overflow gave no request");

	chan_flag_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		|channel_event
		|=> (flags_reg[cat_pkg::FLAG_CH0 +: cat_pkg::CHANNELS]
		& $past(channel_event)) == $past(channel_event))
		else $error("channel event did not set its flag");

	flag_keep_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		flags_reg[cat_pkg::FLAG_CF]
		&& !(rd_done && paddr == cat_pkg::ADDR_FLAGS)
		|=> flags_reg[cat_pkg::FLAG_CF])
		else $error("overflow flag cleared without a software read");

	read_still_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd_done && !advance |=> count_reg == $past(count_reg))
		else $error("a register read moved the count");

	rsvd_stop_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_reg.timebase_select == cat_pkg::CAT_TB_RSVD |-> !tick)
		else $error("reserved timebase advanced the count");
endmodule : cat_counter_array
`default_nettype wire

// *** tb/cat_far_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module cat_far_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [5:0]  ev_req,
	input  wire logic [5:0]  io_req,
	output var cat_pkg::cat_src_t src,
	output logic      [5:0]  channel_event,
	output logic      [5:0]  channel_io_line,
	input  wire logic        irq_request,
	input  wire logic [1:0]  core_enables,
	output logic             core_irq_taken
);
	logic [7:0] tick_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= '0;
			src <= '0;
			channel_event <= '0;
			channel_io_line <= '0;
		end else begin
			tick_reg <= tick_reg + 8'h01;
			src.timer0_overflow <= (tick_reg[2:0] == 3'h7);
			// falls once per 8 clocks, inside the clock/4 ceiling
			src.external_count_input <= tick_reg[2];
			// slow oscillators so the synchroniser never misses an edge
			src.ext_osc <= tick_reg[3];
			src.lf_osc <= tick_reg[4];
			channel_event <= ev_req;
			channel_io_line <= io_req;
		end
	end

	// the core takes the merged request only with both its enables set
	assign core_irq_taken = irq_request && &core_enables;
endmodule : cat_far_model
`default_nettype wire

// *** tb/counter_array_timebase_irq_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module counter_array_timebase_irq_tb;
	logic              pclk, presetn, psel, penable, pwrite, cpu_idle;
	logic [7:0]        paddr;
	logic [31:0]       pwdata, prdata;
	logic              pready, pslverr, irq, wd, taken;
	logic [5:0]        ev, io, pe, m, chev, chio, pin_out, pin_oe;
	logic [15:0]       cnt;
	logic [1:0]        cls, cen;
	cat_pkg::cat_src_t src;
	logic [32:0]       expq[$];
	int                bad_count, check_count, cyc;

	cat_counter_array i_cat_counter_array (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_idle(cpu_idle), .count_sources(src),
		.channel_event(chev), .channel_io_line(chio),
		.channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
		.count_value(cnt), .cycle_length_select(cls),
		.watchdog_mode(wd), .irq_request(irq));
	cat_far_model i_cat_far_model (.pclk(pclk), .presetn(presetn),
		.ev_req(ev), .io_req(io), .src(src), .channel_event(chev),
		.channel_io_line(chio), .irq_request(irq), .core_enables(cen),
		.core_irq_taken(taken));

	task summarize;
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize

	task cmp(input logic [32:0] e, input logic [32:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp

	// level outputs: interrupt line plus the pin routing
	task chk(input logic b);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		cmp({19'h0, b && &cen, b, pe, io & pe},
			{19'h0, taken, irq, pin_oe, pin_out});
	endtask : chk

	// status outputs: watchdog copy, cycle length copy and the count
	task chkst(input logic [18:0] e);
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		cmp({14'h0, e}, {14'h0, wd, cls, cnt});
	endtask : chkst

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			bad_count++;
			summarize();
		end
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [7:0] a, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask : rd

	task setcnt(input logic [15:0] v);
		wr(cat_pkg::ADDR_COUNT_LOW, {24'h0, v[7:0]});
		wr(cat_pkg::ADDR_COUNT_HIGH, {24'h0, v[15:8]});
	endtask : setcnt

	function automatic logic [31:0] md(input logic [2:0] t,
		input logic [1:0] c, input logic i);
		return {26'h0, c, t, i};
	endfunction : md

	always @(negedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (expq.size() == 0)
				cmp('x, {pslverr, prdata});
			else
				cmp(expq.pop_front(), {pslverr, prdata});
		end
	end

	// whole run needs a few thousand cycles
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite, cpu_idle} = '0;
		{paddr, pwdata, ev, io, pe} = '0;
		cen = 2'b11;
		void'($urandom(32'h028a2ddb));
		repeat (7) @(posedge pclk);
		chkst({1'b1, 2'h0, 16'h0});
		@(posedge pclk);
		presetn <= 1'b1;
		rd(cat_pkg::ADDR_MODE, 33'h40);
		wr(cat_pkg::ADDR_COUNT_LOW, 32'h55);
		rd(cat_pkg::ADDR_COUNT_LOW, 33'h0);
		rd(8'h18, {1'b1, 32'h0});
		wr(cat_pkg::ADDR_MODE, 32'h0);
		wr(cat_pkg::ADDR_MODE, md(3'h7, 2'h0, 1'b0));
		rd(cat_pkg::ADDR_MODE, {1'b0, md(3'h7, 2'h0, 1'b0)});
		setcnt(16'h1234);
		chkst({1'b0, 2'h0, 16'h1234});
		rd(cat_pkg::ADDR_COUNT_LOW, 33'h34);
		wr(cat_pkg::ADDR_COUNT_HIGH, 32'h56);
		rd(cat_pkg::ADDR_COUNT_HIGH, 33'h12);
		rd(cat_pkg::ADDR_COUNT_LOW, 33'h34);
		rd(cat_pkg::ADDR_COUNT_HIGH, 33'h56);
		for (int c = 0; c < 4; c++) begin
			setcnt(16'((1 << (8 + c)) - 2));
			wr(cat_pkg::ADDR_MODE, md(3'h7, 2'(c), 1'b0));
			chkst({1'b0, 2'(c), 16'((1 << (8 + c)) - 2)});
			wr(cat_pkg::ADDR_MODE, md(3'h4, 2'(c), 1'b0));
			repeat (8) @(posedge pclk);
			wr(cat_pkg::ADDR_MODE, md(3'h7, 2'(c), 1'b0));
			rd(cat_pkg::ADDR_FLAGS, 33'h2);
		end
		// a carry below the selected bit must not count
		setcnt(16'h00fe);
		wr(cat_pkg::ADDR_MODE, md(3'h4, 2'h3, 1'b0));
		repeat (8) @(posedge pclk);
		wr(cat_pkg::ADDR_MODE, md(3'h7, 2'h3, 1'b0));
		rd(cat_pkg::ADDR_FLAGS, 33'h0);
		wr(cat_pkg::ADDR_IRQ_ENABLE, 32'h3);
		for (int t = 0; t < 8; t++) begin
			setcnt(16'hffff);
			wr(cat_pkg::ADDR_MODE, md(3'(t), 2'h0, 1'b0));
			repeat (300) @(posedge pclk);
			wr(cat_pkg::ADDR_MODE, md(3'h7, 2'h0, 1'b0));
			chk(t != 7);
			rd(cat_pkg::ADDR_FLAGS, (t == 7) ? 33'h0 : 33'h3);
		end
		setcnt(16'hfff0);
		cpu_idle <= 1'b1;
		wr(cat_pkg::ADDR_MODE, md(3'h4, 2'h0, 1'b1));
		repeat (40) @(posedge pclk);
		wr(cat_pkg::ADDR_MODE, md(3'h7, 2'h0, 1'b1));
		rd(cat_pkg::ADDR_COUNT_LOW, 33'hf0);
		rd(cat_pkg::ADDR_FLAGS, 33'h0);
		wr(cat_pkg::ADDR_MODE, md(3'h4, 2'h0, 1'b0));
		repeat (40) @(posedge pclk);
		wr(cat_pkg::ADDR_MODE, md(3'h7, 2'h0, 1'b0));
		cpu_idle <= 1'b0;
		rd(cat_pkg::ADDR_FLAGS, 33'h3);
		m = 6'($urandom()) | 6'h01;
		pe = 6'($urandom());
		io <= 6'($urandom());
		wr(cat_pkg::ADDR_IRQ_ENABLE, 32'h0);
		wr(cat_pkg::ADDR_PIN_ENABLE, {26'h0, pe});
		@(posedge pclk);
		ev <= m;
		@(posedge pclk);
		ev <= 6'h0;
		chk(1'b0);
		wr(cat_pkg::ADDR_IRQ_ENABLE, 32'h4);
		chk(1'b1);
		@(posedge pclk);
		cen <= 2'b10;
		chk(1'b1);
		rd(cat_pkg::ADDR_FLAGS, {25'h0, m, 2'b00});
		chk(1'b0);
		summarize();
	end
endmodule : counter_array_timebase_irq_tb
`default_nettype wire
